// ---- hdl/dss_device.sv ----
// device end of the deep sleep mode sequencer: enable registers, sleep
// control, wake detection, interrupt line and power/clock gating outputs.
// assumes all inputs are synchronous to ref_clk; host keeps its rules.
//
// Contract
// - display sleep: regulator low, always-on block only
// - host puts unused pins analog first; dss_host configures no pins
// - host writes enables 0x1900 first
// - host sets bandgap 0xc0 or 0x80
// - pin low, set bits, pin rise enters
// - pending wake blocks entry, irq stays low
// - host checks irq quiet 100 us
// - irq after entry means woke, reinit
// - host keeps wake interrupts enabled
// - stay asleep until wake, then irq
// - pin low wakes, host reinitialises
// - hold ports asleep, reset ports on wake
// - bypass bit selects external clock
// - external clock: oscillator off, detection kept
// - clock sleep drops LCD
// - host sets bandgap, match enable, masks
// - shutdown disables all, only reset exits
// - host shutdown sequence with oscillator off
// - irq after shutdown: host resets, retries; dss_host only raises need_reset, no retry
// - host clears masks before shutdown
// - oscillator stops after two rtc ticks in shutdown
// - pin fall wakes, self-clears enables
// - wake cause kept in status bits
`timescale 1ns/1ps
`default_nettype none
module dss_device (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  // host side
  dss_if.device      bus,
  // always-on event inputs
  input  wire logic  rtc_tick,
  input  wire logic  alarm_evt,
  input  wire logic  osc_fail_evt,
  input  wire logic  match_level,
  // power and clock controls
  output logic       regulator_low,
  output logic       logic_power_off,
  output logic       lcd_refresh_on,
  output logic       rtc_osc_on,
  output logic       rtc_clock_bypass,
  output logic       ports_hold,
  output logic       ports_default,
  output logic [1:0] sleep_state
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    DSS_AWAKE    = 4'b0001,
    DSS_LCD      = 4'b0010,
    DSS_CLOCK    = 4'b0100,
    DSS_SHUTDOWN = 4'b1000
  } dss_state_e;

  dss_state_e state_reg, state_next;
  logic [7:0] irq_en_low_reg, irq_en_high_reg, misc_config_reg;
  logic [7:0] deep_sleep_control_reg, master_control_reg;
  logic [7:0] rtc_control_reg, match_mask_reg;
  logic [2:0] wake_source_status;
  logic       pin_q_reg, rstc_reg, irq_n_reg;
  logic [7:0] rdata_reg;
  logic [1:0] osc_cnt_reg;
  logic       regulator_low_reg, logic_off_reg, lcd_on_reg;
  logic       osc_on_reg, ports_hold_reg, ports_def_reg;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  // pin edges and bus strobes
  wire pin_rise   = bus.power_down_pin_n & ~pin_q_reg;
  wire pin_fall   = ~bus.power_down_pin_n & pin_q_reg;
  wire awake      = state_reg == DSS_AWAKE;
  wire asleep     = ~awake & (state_reg != DSS_SHUTDOWN);
  wire wr_sleep   = bus.reg_wr & (bus.reg_addr == dss_pkg::ADDR_SLEEP_CTRL);
  wire wr_master  = bus.reg_wr & (bus.reg_addr == dss_pkg::ADDR_MASTER_CTRL);
  wire match_en   = deep_sleep_control_reg[dss_pkg::BIT_MATCH_EN];
  wire lcd_keep   = deep_sleep_control_reg[dss_pkg::BIT_LCD_KEEP];
  wire osc_off    = deep_sleep_control_reg[dss_pkg::BIT_OSC_OFF];
  wire match_pol  = deep_sleep_control_reg[dss_pkg::BIT_MATCH_POL];
  // alarm and fail detection only while the oscillator runs or is bypassed
  wire detect_ok  = osc_on_reg | master_control_reg[dss_pkg::BIT_CLK_BYPASS];
  wire ev_match   = ((match_level ^ match_pol) & |match_mask_reg)
                    & irq_en_low_reg[dss_pkg::BIT_EN_MATCH];
  wire ev_alarm   = alarm_evt & detect_ok & irq_en_low_reg[dss_pkg::BIT_EN_ALARM];
  wire ev_fail    = osc_fail_evt & detect_ok
                    & irq_en_low_reg[dss_pkg::BIT_EN_FAIL];
  wire [2:0] ev_vec = {ev_fail, ev_alarm, ev_match};
  wire pending    = (|wake_source_status) | rstc_reg;
  // entry takes the requested mode at the pin rise, if nothing is pending and match_en or lcd_keep is set
  wire enter_ok   = awake & pin_rise & ~pending & (match_en | lcd_keep);
  wire wake_evt   = asleep & (|ev_vec) & match_en;
  wire wake_pin   = asleep & pin_fall;
  wire wake_any   = wake_evt | wake_pin | (asleep & ~match_en & |ev_vec);
  wire status_clr = wr_master & bus.reg_wdata[dss_pkg::BIT_STATUS_CLEAR];

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DSS_AWAKE: begin
        if (enter_ok && osc_off) begin
          state_next = DSS_SHUTDOWN;
        end else if (enter_ok && lcd_keep) begin
          state_next = DSS_LCD;
        end else if (enter_ok) begin
          state_next = DSS_CLOCK;
        end
      end
      DSS_LCD, DSS_CLOCK: begin
        if (wake_any) begin
          state_next = DSS_AWAKE;
        end
      end
      DSS_SHUTDOWN: state_next = DSS_SHUTDOWN;
    endcase
  end

  // -------------------------------------------------------------------
  // registers written by the host
  // -------------------------------------------------------------------
  // register writes only take effect while awake
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_low_reg  <= dss_pkg::IRQ_EN_LOW_RST;
      irq_en_high_reg <= dss_pkg::IRQ_EN_HIGH_RST;
      misc_config_reg <= dss_pkg::ZERO8;
      master_control_reg <= dss_pkg::ZERO8;
      rtc_control_reg <= dss_pkg::RTC_CTRL_RST;
      match_mask_reg  <= dss_pkg::ZERO8;
    end else if (asleep && state_next == DSS_AWAKE) begin
      irq_en_low_reg  <= dss_pkg::IRQ_EN_LOW_RST;
      irq_en_high_reg <= dss_pkg::IRQ_EN_HIGH_RST; // unpreserved on wake
    end else if (bus.reg_wr && awake) begin
      unique case (bus.reg_addr)
        dss_pkg::ADDR_IRQ_EN_LOW:  irq_en_low_reg  <= bus.reg_wdata;
        dss_pkg::ADDR_IRQ_EN_HIGH: irq_en_high_reg <= bus.reg_wdata;
        dss_pkg::ADDR_MISC_CONFIG: misc_config_reg <= bus.reg_wdata;
        dss_pkg::ADDR_MASTER_CTRL: master_control_reg <= bus.reg_wdata;
        dss_pkg::ADDR_RTC_CTRL:    rtc_control_reg <= bus.reg_wdata;
        dss_pkg::ADDR_MATCH_MASK:  match_mask_reg  <= bus.reg_wdata;
        default: ;
      endcase
    end
  end

  // sleep control: enables self-clear on wake-up
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      deep_sleep_control_reg <= dss_pkg::ZERO8;
    end else if (asleep && state_next == DSS_AWAKE) begin
      deep_sleep_control_reg <= deep_sleep_control_reg
        & ~((8'h01 << dss_pkg::BIT_LCD_KEEP) | (8'h01 << dss_pkg::BIT_MATCH_EN)
          | (8'h01 << dss_pkg::BIT_OSC_OFF));
    end else if (wr_sleep && awake) begin
      deep_sleep_control_reg <= bus.reg_wdata & dss_pkg::SLEEP_CTRL_WMASK;
    end
  end

  // wake cause status: an event at an awake pin rise wins over a clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_source_status <= 3'h0;
    end else if (asleep) begin
      wake_source_status <= wake_source_status | ev_vec;
    end else if (status_clr) begin
      wake_source_status <= ev_vec & {3{awake & pin_rise}};
    end else if (awake && pin_rise) begin
      wake_source_status <= wake_source_status | ev_vec;
    end
  end

  // state, pin history, reset-complete flag and interrupt line
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DSS_AWAKE;
      pin_q_reg <= 1'b1;  // idle level, no false edge after reset
      rstc_reg  <= 1'b1;
      irq_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      pin_q_reg <= bus.power_down_pin_n;
      if (asleep && state_next == DSS_AWAKE) begin
        rstc_reg <= 1'b1;
      end else if (status_clr) begin
        rstc_reg <= 1'b0;
      end
      irq_n_reg <= ~((rstc_reg & irq_en_high_reg[dss_pkg::BIT_EN_RSTC])
                     | (awake & |wake_source_status)
                     | (awake & bus.power_down_pin_n & pending));
    end
  end

  // read port: data stands the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg   <= dss_pkg::ZERO8;
    end else begin
      unique case (bus.reg_addr)
        dss_pkg::ADDR_IRQ_EN_LOW:  rdata_reg <= irq_en_low_reg;
        dss_pkg::ADDR_IRQ_EN_HIGH: rdata_reg <= irq_en_high_reg;
        dss_pkg::ADDR_MISC_CONFIG: rdata_reg <= misc_config_reg;
        dss_pkg::ADDR_WAKE_STATUS: rdata_reg <= {5'h00, wake_source_status};
        dss_pkg::ADDR_MASTER_CTRL: rdata_reg <= master_control_reg;
        dss_pkg::ADDR_RTC_CTRL:    rdata_reg <= rtc_control_reg;
        dss_pkg::ADDR_SLEEP_CTRL:  rdata_reg <= deep_sleep_control_reg;
        dss_pkg::ADDR_MATCH_MASK:  rdata_reg <= match_mask_reg;
        default:                   rdata_reg <= dss_pkg::ZERO8;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // power and clock gating outputs
  // -------------------------------------------------------------------
  // oscillator stops after two rtc_tick pulses following entry with osc_off set
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_reg       <= 2'h0;
      osc_on_reg        <= 1'b1;
      regulator_low_reg <= 1'b0;
      logic_off_reg     <= 1'b0;
      lcd_on_reg        <= 1'b1;
      ports_hold_reg    <= 1'b0;
      ports_def_reg     <= 1'b1;
    end else begin
      regulator_low_reg <= state_next != DSS_AWAKE;
      logic_off_reg     <= state_next != DSS_AWAKE;
      lcd_on_reg        <= (state_next == DSS_AWAKE)
                           | (state_next == DSS_LCD);
      ports_hold_reg    <= state_next != DSS_AWAKE;
      if (asleep && state_next == DSS_AWAKE) begin
        ports_def_reg <= 1'b1;
      end else if (bus.reg_wr && awake) begin
        ports_def_reg <= 1'b0;
      end
      if (state_reg == DSS_SHUTDOWN) begin
        if (rtc_tick && osc_cnt_reg != 2'(dss_pkg::OSC_STOP_EDGES)) begin
          osc_cnt_reg <= osc_cnt_reg + 2'h1;
        end
        osc_on_reg <= osc_cnt_reg != 2'(dss_pkg::OSC_STOP_EDGES);
      end else begin
        osc_cnt_reg <= 2'h0;
        osc_on_reg  <= rtc_control_reg != dss_pkg::RTC_CTRL_OFF;
      end
    end
  end

  assign bus.irq_n        = irq_n_reg;
  assign bus.reg_rdata    = rdata_reg;
  assign regulator_low    = regulator_low_reg;
  assign logic_power_off  = logic_off_reg;
  assign lcd_refresh_on   = lcd_on_reg;
  assign rtc_osc_on       = osc_on_reg;
  assign rtc_clock_bypass = master_control_reg[dss_pkg::BIT_CLK_BYPASS];
  assign ports_hold       = ports_hold_reg;
  assign ports_default    = ports_def_reg;
  assign sleep_state      = {state_reg == DSS_SHUTDOWN | state_reg == DSS_CLOCK,
                             state_reg == DSS_SHUTDOWN | state_reg == DSS_LCD};
endmodule
`default_nettype wire

// ---- include/dss_pkg.sv ----
// package for the deep sleep mode sequencer: register offsets, bit
// positions, values and timing shared by both ends.
// assumes a single 100 MHz ref_clk domain.
package dss_pkg;
  // -------------------------------------------------------------------
  // device register map, 8-bit registers reached over the carrier
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_EN_LOW   = 8'h30;
  localparam logic [7:0] ADDR_IRQ_EN_HIGH  = 8'h31;
  localparam logic [7:0] ADDR_MISC_CONFIG  = 8'h40;
  localparam logic [7:0] ADDR_WAKE_STATUS  = 8'h42;
  localparam logic [7:0] ADDR_MASTER_CTRL  = 8'h50;
  localparam logic [7:0] ADDR_RTC_CTRL     = 8'h60;
  localparam logic [7:0] ADDR_SLEEP_CTRL   = 8'ha2;
  localparam logic [7:0] ADDR_MATCH_MASK   = 8'ha3;

  // sleep control bits
  localparam int BIT_MATCH_POL   = 0;
  localparam int BIT_MATCH_EN    = 1;
  localparam int BIT_LCD_KEEP    = 3;
  localparam int BIT_OSC_OFF     = 4;
  localparam logic [7:0] SLEEP_CTRL_WMASK = 8'h1b;
  // master control bits
  localparam int BIT_STATUS_CLEAR = 6;
  localparam int BIT_CLK_BYPASS   = 7;
  // wake status bits
  localparam int BIT_WAKE_MATCH  = 0;
  localparam int BIT_WAKE_ALARM  = 1;
  localparam int BIT_WAKE_FAIL   = 2;
  // interrupt enable low bits, reset-complete in the high byte
  localparam int BIT_EN_MATCH    = 0;
  localparam int BIT_EN_ALARM    = 3;
  localparam int BIT_EN_FAIL     = 4;
  localparam int BIT_EN_RSTC     = 4;

  // -------------------------------------------------------------------
  // reset values and host programming values
  // -------------------------------------------------------------------
  localparam logic [7:0]  IRQ_EN_LOW_RST   = 8'hef;
  localparam logic [7:0]  IRQ_EN_HIGH_RST  = 8'hff;
  localparam logic [7:0]  RTC_CTRL_RST     = 8'h80;
  localparam logic [15:0] IRQ_EN_SLEEP     = 16'h1900;
  localparam logic [7:0]  BANDGAP_LCD      = 8'hc0;
  localparam logic [7:0]  BANDGAP_LOWEST   = 8'h80;
  localparam logic [7:0]  RTC_CTRL_OFF     = 8'h00;
  localparam logic [7:0]  ZERO8            = 8'h00;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int INT_QUIET_US     = 100;
  localparam int INT_QUIET_CYC    = INT_QUIET_US * CLK_MHZ;
  localparam int OSC_STOP_EDGES   = 2;

  // host commands on its user port
  localparam logic [1:0] CMD_LCD      = 2'h0;
  localparam logic [1:0] CMD_CLOCK    = 2'h1;
  localparam logic [1:0] CMD_SHUTDOWN = 2'h2;
  localparam logic [1:0] CMD_WAKE     = 2'h3;
endpackage

// ---- include/dss_if.sv ----
// carrier between the host end and the device end of the sequencer.
// assumes both ends share ref_clk; all signals are plain levels.
`timescale 1ns/1ps
`default_nettype none
interface dss_if;
  logic       power_down_pin_n;  // low = awake request, rise = sleep
  logic       reg_wr;            // one-cycle register write
  logic       reg_rd;            // one-cycle register read
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;         // valid the cycle after reg_rd
  logic       irq_n;             // active-low interrupt line

  modport device (
    input  power_down_pin_n, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, irq_n
  );
  modport host (
    output power_down_pin_n, reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, irq_n
  );
endinterface
`default_nettype wire

// ---- hdl/dss_host.sv ----
// host end of the deep sleep mode sequencer: runs the entry, wake and
// shutdown procedures on command and reports the outcome.
// assumes the device end on the same ref_clk across dss_if.
`timescale 1ns/1ps
`default_nettype none
module dss_host #(
  parameter int QUIET_CYC = dss_pkg::INT_QUIET_CYC
) (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  // device side
  dss_if.host        bus,
  // user command port
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd,
  input  wire logic       want_match,
  input  wire logic       loose_bandgap,
  output logic            busy,
  output logic            done,
  output logic            woke,
  output logic            need_reinit,
  output logic            need_reset
);
  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  typedef enum logic [5:0] {
    HS_IDLE  = 6'b000001,
    HS_WRITE = 6'b000010,
    HS_RISE  = 6'b000100,
    HS_QUIET = 6'b001000,
    HS_WAKE  = 6'b010000,
    HS_DONE  = 6'b100000
  } hs_state_e;

  hs_state_e  st_reg;
  logic [2:0] step_reg;
  logic [1:0] cmd_reg;
  logic       match_reg, loose_reg, pin_reg, wr_reg;
  logic [7:0] addr_reg, data_reg;
  logic [31:0] cnt_reg;
  logic       busy_reg, done_reg, woke_reg, reinit_reg, nreset_reg;

  // write list for each step: enables, masks, bandgap, then sleep control
  wire [7:0] gap = (cmd_reg == dss_pkg::CMD_LCD && !loose_reg)
                   ? dss_pkg::BANDGAP_LCD : dss_pkg::BANDGAP_LOWEST;
  wire [7:0] sleep_bits =
      (cmd_reg == dss_pkg::CMD_SHUTDOWN) ? 8'h12 :
      (cmd_reg == dss_pkg::CMD_LCD) ? {4'h0, 1'b1, 1'b0, match_reg, 1'b0} :
      8'h02;
  wire clr_mask = (cmd_reg == dss_pkg::CMD_SHUTDOWN) || !match_reg;
  wire [7:0] step_addr =
      (step_reg == 3'h0) ? dss_pkg::ADDR_IRQ_EN_LOW :
      (step_reg == 3'h1) ? dss_pkg::ADDR_IRQ_EN_HIGH :
      (step_reg == 3'h2) ? dss_pkg::ADDR_MATCH_MASK :
      (step_reg == 3'h3) ? dss_pkg::ADDR_MISC_CONFIG :
                           dss_pkg::ADDR_SLEEP_CTRL;
  wire [7:0] step_data =
      (step_reg == 3'h0) ? dss_pkg::IRQ_EN_SLEEP[15:8] :
      (step_reg == 3'h1) ? dss_pkg::IRQ_EN_SLEEP[7:0] :
      (step_reg == 3'h2) ? (clr_mask ? dss_pkg::ZERO8 : 8'hff) :
      (step_reg == 3'h3) ? gap : sleep_bits;
  wire irq_low   = ~bus.irq_n;
  wire quiet_end = cnt_reg == 32'(QUIET_CYC - 1);

  // one process runs the whole procedure
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= HS_IDLE;
      step_reg <= 3'h0;
      cmd_reg <= dss_pkg::CMD_LCD;
      match_reg <= 1'b0;
      loose_reg <= 1'b0;
      pin_reg <= 1'b1;
      wr_reg <= 1'b0;
      addr_reg <= dss_pkg::ZERO8;
      data_reg <= dss_pkg::ZERO8;
      cnt_reg <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      woke_reg <= 1'b0;
      reinit_reg <= 1'b0;
      nreset_reg <= 1'b0;
    end else begin
      wr_reg   <= 1'b0;
      done_reg <= 1'b0;
      unique case (st_reg)
        HS_IDLE: if (cmd_valid) begin
          cmd_reg <= cmd;
          match_reg <= want_match;
          loose_reg <= loose_bandgap;
          busy_reg <= 1'b1;
          woke_reg <= 1'b0;
          reinit_reg <= 1'b0;
          nreset_reg <= 1'b0;
          step_reg <= 3'h0;
          cnt_reg <= 32'h0;
          pin_reg <= 1'b0;
          st_reg <= (cmd == dss_pkg::CMD_WAKE) ? HS_WAKE : HS_WRITE;
        end
        HS_WRITE: begin
          wr_reg   <= 1'b1;
          addr_reg <= step_addr;
          data_reg <= step_data;
          step_reg <= step_reg + 3'h1;
          if (step_reg == 3'h4) begin
            st_reg <= HS_RISE;
          end
        end
        HS_RISE: begin
          pin_reg <= 1'b1;
          st_reg  <= HS_QUIET;
        end
        HS_QUIET: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (irq_low) begin
            woke_reg   <= 1'b1;
            reinit_reg <= 1'b1;
            nreset_reg <= cmd_reg == dss_pkg::CMD_SHUTDOWN;
            st_reg     <= HS_DONE;
          end else if (quiet_end) begin
            st_reg <= HS_DONE;
          end
        end
        HS_WAKE: if (irq_low) begin
          woke_reg   <= 1'b1;
          reinit_reg <= 1'b1;
          st_reg     <= HS_DONE;
        end
        HS_DONE: begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          st_reg   <= HS_IDLE;
        end
      endcase
    end
  end

  assign bus.power_down_pin_n = pin_reg;
  assign bus.reg_wr    = wr_reg;
  assign bus.reg_rd    = 1'b0;
  assign bus.reg_addr  = addr_reg;
  assign bus.reg_wdata = data_reg;
  assign busy        = busy_reg;
  assign done        = done_reg;
  assign woke        = woke_reg;
  assign need_reinit = reinit_reg;
  assign need_reset  = nreset_reg;
endmodule
`default_nettype wire

// ---- test/dss_properties.sv ----
// checker on the carrier between the host end and the device end.
// assumes one ref_clk domain; sees only the carrier's signals.
`timescale 1ns/1ps
`default_nettype none
module dss_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // carrier
  input wire logic       power_down_pin_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       irq_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----
  // host write cycles and irq hold after entry
  // ----
  sequence s_ctl;
    reg_wr && reg_addr == 8'ha2;
  endsequence
  property p_one; !(reg_wr && reg_rd); endproperty
  a_one: assert property (p_one) else $error("both strobes high");
  property p_pin; reg_wr |-> !power_down_pin_n; endproperty
  a_pin: assert property (p_pin) else $error("write with pin high");
  property p_rise; s_ctl |-> ##[1:4] $rose(power_down_pin_n); endproperty
  a_rise: assert property (p_rise) else $error("no pin rise");
  property p_lo; reg_wr && reg_addr == 8'h30 |-> reg_wdata == 8'h19;
  endproperty
  a_lo: assert property (p_lo) else $error("bad low enable");
  property p_hi; reg_wr && reg_addr == 8'h31 |-> reg_wdata == 8'h00;
  endproperty
  a_hi: assert property (p_hi) else $error("bad high enable");
  property p_bg;
    reg_wr && reg_addr == 8'h40 |-> reg_wdata inside {8'hc0, 8'h80};
  endproperty
  a_bg: assert property (p_bg) else $error("bad bandgap");
  property p_mask; s_ctl ##0 reg_wdata[4] |->
    $past(reg_addr, 2) == 8'ha3 && $past(reg_wdata, 2) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("mask not clear");
  property p_off; s_ctl ##0 reg_wdata[4] |-> reg_wdata[1]; endproperty
  a_off: assert property (p_off) else $error("osc off alone");
  property p_keep; $rose(power_down_pin_n) ##1 !irq_n |=> !irq_n [*3];
  endproperty
  a_keep: assert property (p_keep) else $error("irq released");
endmodule
`default_nettype wire

// ---- test/deep_sleep_mode_sequencer_test.sv ----
// bench: host end and device end on one carrier, and a second
// device end worked by bench tasks on a carrier of its own.
// assumes package, carrier, both ends and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module deep_sleep_mode_sequencer_test;
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic       loose = 1'b0;
  logic       tick_in = 1'b0;
  logic [2:0] evt = 3'h0;
  int         fails = 0;
  int         tests_run = 0;
  wire logic  done, need_reinit, need_reset, woke;
  wire logic  [1:0] b_st;
  wire logic  b_low, b_off, b_lcd, b_osc, b_byp, b_hold, b_dflt;
  dss_if bus_a ();
  dss_if bus_b ();
  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // ----
  // design ends and checker
  // ----
  dss_host #(.QUIET_CYC(20)) u_dss_host (.ref_clk(ref_clk), .arst_n(arst_n),
    .bus(bus_a.host), .cmd_valid(cmd_valid), .cmd(cmd), .want_match(1'b1),
    .loose_bandgap(loose), .busy(), .done(done), .woke(woke),
    .need_reinit(need_reinit), .need_reset(need_reset));
  dss_device u_dss_device (.ref_clk(ref_clk), .arst_n(arst_n),
    .bus(bus_a.device), .rtc_tick(tick_in), .alarm_evt(evt[1]),
    .osc_fail_evt(evt[2]), .match_level(evt[0]), .regulator_low(),
    .logic_power_off(), .lcd_refresh_on(), .rtc_osc_on(),
    .rtc_clock_bypass(), .ports_hold(), .ports_default(), .sleep_state());
  dss_device u_dss_device_b (.ref_clk(ref_clk), .arst_n(arst_n),
    .bus(bus_b.device), .rtc_tick(tick_in), .alarm_evt(evt[1]),
    .osc_fail_evt(evt[2]), .match_level(evt[0]), .regulator_low(b_low),
    .logic_power_off(b_off), .lcd_refresh_on(b_lcd), .rtc_osc_on(b_osc),
    .rtc_clock_bypass(b_byp), .ports_hold(b_hold),
    .ports_default(b_dflt), .sleep_state(b_st));
  dss_properties u_dss_properties (.ref_clk(ref_clk), .arst_n(arst_n),
    .power_down_pin_n(bus_a.power_down_pin_n), .reg_wr(bus_a.reg_wr),
    .reg_rd(bus_a.reg_rd), .reg_addr(bus_a.reg_addr),
    .reg_wdata(bus_a.reg_wdata), .irq_n(bus_a.irq_n));
  // ----
  // bench tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus_b.reg_addr <= a;
    bus_b.reg_wdata <= v;
    bus_b.reg_wr <= 1'b1;
    tick(1);
    bus_b.reg_wr <= 1'b0;
    tick(1);
  endtask
  // read data stand from the cycle after the address is set, strobe or not
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    bus_b.reg_addr <= a;
    bus_b.reg_rd <= 1'b1;
    tick(1);
    bus_b.reg_rd <= 1'b0;
    #1 `CHK(n, e, bus_b.reg_rdata)
    tick(1);
  endtask
  task automatic pin(input logic v);
    bus_b.power_down_pin_n <= v;
    tick(1);
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 64 && bus_b.irq_n !== 1'b0; k++) tick(1);
    if (bus_b.irq_n !== 1'b0) begin
      fails++;
      conclude();
    end
  endtask
  // clear status, program enables and bandgap, then pin rise
  task automatic enter(input logic [7:0] v);
    wr(8'h50, 8'h40);
    pin(1'b0);
    wr(8'h30, 8'h19);
    wr(8'h31, 8'h00);
    wr(8'ha3, v[4] ? 8'h00 : 8'hff);
    wr(8'h40, 8'h80);
    wr(8'ha2, v);
    pin(1'b1);
    tick(3);
  endtask
  task automatic run(input logic [1:0] c);
    tick(1);
    cmd <= c;
    loose <= c[0];
    cmd_valid <= 1'b1;
    tick(1);
    cmd_valid <= 1'b0;
    for (int k = 0; k < 200 && done !== 1'b1; k++) tick(1);
    if (done !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask
  // main sequence
  initial begin
    bus_b.power_down_pin_n = 1'b1;
    bus_b.reg_wr = 1'b0;
    bus_b.reg_rd = 1'b0;
    bus_b.reg_addr = 8'h00;
    bus_b.reg_wdata = 8'h00;
    tick(3);
    arst_n <= 1'b1;
    tick(2);
    for (int c = 0; c < 3; c++) begin
      run(c[1:0]);
      if (c < 2) `CHK("reinit", 1'b1, need_reinit)
      else `CHK("reset req", 1'b1, need_reset)
      `CHK("woke", 1'b1, woke)
    end
    run(dss_pkg::CMD_WAKE);
    `CHK("wake woke", 1'b1, woke)
    $display("host command test done");
    rd("en low", 8'h30, 8'hef);
    rd("en high", 8'h31, 8'hff);
    rd("unmapped", 8'h77, 8'h00);
    pin(1'b0);
    wr(8'ha2, 8'h08);
    pin(1'b1);
    tick(3);
    `CHK("refused", 2'h0, b_st)
    `CHK("irq kept", 1'b0, bus_b.irq_n)
    $display("refusal test done");
    for (int i = 0; i < 3; i++) begin
      enter(i[0] ? 8'h02 : 8'h0a);
      `CHK("quiet", 1'b1, bus_b.irq_n)
      `CHK("mode", i[0] ? 2'h2 : 2'h1, b_st)
      `CHK("lcd", ~i[0], b_lcd)
      `CHK("power", 3'h7, {b_low, b_off, b_hold})
      evt <= 3'h1 << i;
      wait_irq();
      `CHK("awake", 2'h0, b_st)
      evt <= 3'h0;
      tick(3);
      `CHK("ports", 1'b1, b_dflt)
      rd("cause", 8'h42, 8'h01 << i);
      rd("ctl", 8'ha2, 8'h00);
    end
    enter(8'h08);
    pin(1'b0);
    wait_irq();
    rd("pin cause", 8'h42, 8'h00);
    $display("wake test done");
    enter(8'h12);
    `CHK("shut", 2'h3, b_st)
    tick_in <= 1'b1;
    tick(1);
    tick_in <= 1'b0;
    tick(1);
    `CHK("osc on", 1'b1, b_osc)
    tick_in <= 1'b1;
    tick(1);
    tick_in <= 1'b0;
    tick(3);
    `CHK("osc off", 1'b0, b_osc)
    evt <= 3'h2;
    pin(1'b0);
    tick(10);
    `CHK("stays", 2'h3, b_st)
    evt <= 3'h0;
    arst_n <= 1'b0;
    tick(3);
    arst_n <= 1'b1;
    tick(2);
    `CHK("reset out", 2'h0, b_st)
    wr(8'h50, 8'h80);
    `CHK("bypass", 1'b1, b_byp)
    $display("shutdown test done");
    conclude();
  end
endmodule
`default_nettype wire
